// File: mic_cfg.svh
// Purpose: Constants for the interrupt request controller.
// Assumes: 20 MHz core clock, classic Wishbone register access.
// Notes:   Offsets are byte addresses of 32-bit words.
`ifndef MIC_CFG_SVH
`define MIC_CFG_SVH
`define MIC_OFS_SENS      8'h00
`define MIC_OFS_ENABLE    8'h04
`define MIC_OFS_PENDING   8'h08
`define MIC_OFS_STATUS    8'h0C
`define MIC_SENS_RESET    8'h00
`define MIC_ENABLE_RESET  14'h0000
`define MIC_NSRC          14
`define MIC_VEC_RESET     16'hFFFE
`define MIC_VEC_TRAP      16'hFFFC
`define MIC_VEC_SRC0      16'hFFFA
`define MIC_FIRST_EXT     1
`define MIC_HALT_WAKE     14'h101F
`define MIC_AHALT_WAKE    14'h0A00
`define MIC_AWU_SRC       0
`endif

// File: mic_pkg.sv
// Purpose: Types for the interrupt request controller.
// Assumes: Nothing beyond the constants header.
// Notes:   Power modes are one-hot.
`default_nettype none
package mic_pkg;
    typedef enum logic [4:0]
    {
        MIC_RUN   = 5'h01,
        MIC_WAIT  = 5'h02,
        MIC_HALT  = 5'h04,
        MIC_AHALT = 5'h08,
        MIC_AUTO_WAKEUP_HALT_MODE = 5'h10
    } mic_mode_t;
endpackage
`default_nettype wire

// File: mic_edge_det.sv
// Purpose: Sensitivity decode for one external line.
// Assumes: Source is already pin-selected and synchronous.
// Notes:   Edge events are latched; low level requests directly.
`include "mic_cfg.svh"
`default_nettype none
module mic_edge_det
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Line and configuration.
    input  wire logic       src_i,
    input  wire logic [1:0] sens_i,
    input  wire logic       ack_i,
    // Request.
    output logic            req_o
);
    logic prev_q;
    logic latch_q;
    logic rise;
    logic fall;
    logic ev;
    logic level;

    assign rise  = src_i & ~prev_q;
    assign fall  = ~src_i & prev_q;
    assign ev    = (sens_i == 2'h1) ? rise :
                   (sens_i == 2'h3) ? (rise | fall) : fall;
    assign level = (sens_i == 2'h0) & ~src_i;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_q  <= 1'b1;
            latch_q <= 1'b0;
        end
        else
        begin
            prev_q <= src_i;
            if (ev)
                latch_q <= 1'b1;
            else if (ack_i)
                latch_q <= 1'b0;
        end
    end

    assign req_o = latch_q | level;
endmodule
`default_nettype wire

// File: mic_top.sv
// Purpose: Interrupt request, priority, vector and wake-up logic.
// Assumes: Core signals trap, entry, return and mode entry as pulses.
// Notes:   Sources 0..13 in descending priority order after reset, trap.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`include "mic_cfg.svh"
`default_nettype none
module mic_top
    import mic_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK_I,
    input  wire logic        RESETN_I,
    // Wishbone slave.
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Sources after pin selection.
    input  wire logic [3:0]  EXT_LINE_I,
    input  wire logic [13:0] PERIPH_FLAG_I,
    input  wire logic [13:0] PERIPH_CLEAR_I,
    // Core handshake.
    input  wire logic        TRAP_I,
    input  wire logic        ENTRY_I,
    input  wire logic        RETURN_FROM_IRQ_INSTR_I,
    input  wire logic        WFI_I,
    input  wire logic        HALT_I,
    input  wire logic        AHALT_I,
    input  wire logic        AUTO_WAKEUP_HALT_MODE_I,
    output logic             IRQ_O,
    output logic      [15:0] VECTOR_O,
    output logic             MASK_O,
    output logic             WAKE_O,
    output logic      [4:0]  MODE_O
);
    import mic_pkg::*;

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rs1_q;
    logic rst_n;

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  sens_q;
    logic [13:0] en_q;
    logic [13:0] pend_q;
    logic        mask_q;
    logic        rst_pend_q;
    logic        trap_pend_q;
    logic [3:0]  ext_req;
    logic [13:0] req;
    logic [13:0] unmasked;
    logic [13:0] ack_vec;
    logic        sel_valid;
    logic [3:0]  sel_idx;
    mic_mode_t   mode_q;
    logic        wb_hit;
    logic        wr;

    function automatic logic [15:0] src_vec(input logic [3:0] idx);
        src_vec = `MIC_VEC_SRC0 - {11'h000, idx, 1'b0};
    endfunction

    assign wb_hit = CYC_I & STB_I & ~ACK_O;
    assign wr     = wb_hit & WE_I & SEL_I[0];

    // ------------------------------------------------------------
    // External lines
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ext
            mic_edge_det u_det
            (
                .clk_i   (CLK_I),
                .rst_n_i (rst_n),
                .src_i   (EXT_LINE_I[g]),
                .sens_i  (sens_q[2*g+1 -: 2]),
                .ack_i   (ack_vec[g+1]),
                .req_o   (ext_req[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Pending latches
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            pend_q <= 14'h0000;
        else
            pend_q <= (pend_q | PERIPH_FLAG_I) & ~PERIPH_CLEAR_I & ~ack_vec;
    end

    always_comb
    begin
        req = pend_q;
        req[4:1] = ext_req;
    end

    assign unmasked  = req & en_q & {14{~mask_q}};
    assign sel_valid = |unmasked;

    always_comb
    begin
        sel_idx = 4'h0;
        for (int i = 13; i >= 0; i--)
            if (unmasked[i])
                sel_idx = i[3:0];
    end

    always_comb
    begin
        ack_vec = 14'h0000;
        if (ENTRY_I & ~rst_pend_q & ~trap_pend_q & sel_valid)
            ack_vec[sel_idx] = 1'b1;
    end

    // ------------------------------------------------------------
    // Mask, reset and trap
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_q      <= 1'b1;
            rst_pend_q  <= 1'b1;
            trap_pend_q <= 1'b0;
        end
        else
        begin
            if (ENTRY_I)
                mask_q <= 1'b1;
            else if (RETURN_FROM_IRQ_INSTR_I | WFI_I | HALT_I | AHALT_I | AUTO_WAKEUP_HALT_MODE_I)
                mask_q <= 1'b0;
            if (ENTRY_I)
                rst_pend_q <= 1'b0;
            if (TRAP_I)
                trap_pend_q <= 1'b1;
            else if (ENTRY_I & ~rst_pend_q)
                trap_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Request and vector outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            IRQ_O    <= 1'b0;
            VECTOR_O <= `MIC_VEC_RESET;
            MASK_O   <= 1'b1;
        end
        else
        begin
            IRQ_O  <= rst_pend_q | trap_pend_q | TRAP_I | sel_valid;
            MASK_O <= mask_q;
            if (rst_pend_q)
                VECTOR_O <= `MIC_VEC_RESET;
            else if (trap_pend_q | TRAP_I)
                VECTOR_O <= `MIC_VEC_TRAP;
            else
                VECTOR_O <= src_vec(sel_idx);
        end
    end

    // ------------------------------------------------------------
    // Power mode and wake-up
    // ------------------------------------------------------------
    logic [13:0] wake_set;

    always_comb
    begin
        case (mode_q)
            MIC_WAIT:  wake_set = 14'h3FFF;
            MIC_HALT:  wake_set = `MIC_HALT_WAKE & 14'h3FFE;
            MIC_AUTO_WAKEUP_HALT_MODE: wake_set = `MIC_HALT_WAKE;
            MIC_AHALT: wake_set = `MIC_AHALT_WAKE;
            default:   wake_set = 14'h0000;
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MIC_RUN;
            WAKE_O <= 1'b0;
            MODE_O <= 5'h01;
        end
        else
        begin
            WAKE_O <= 1'b0;
            if (WFI_I)
                mode_q <= MIC_WAIT;
            else if (HALT_I)
                mode_q <= MIC_HALT;
            else if (AHALT_I)
                mode_q <= MIC_AHALT;
            else if (AUTO_WAKEUP_HALT_MODE_I)
                mode_q <= MIC_AUTO_WAKEUP_HALT_MODE;
            else if (mode_q != MIC_RUN && |(req & en_q & wake_set))
            begin
                mode_q <= MIC_RUN;
                WAKE_O <= 1'b1;
            end
            MODE_O <= mode_q;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sens_q <= `MIC_SENS_RESET;
            en_q   <= `MIC_ENABLE_RESET;
        end
        else
        begin
            if (wr && ADR_I == `MIC_OFS_SENS && mask_q)
                sens_q <= DAT_I[7:0];
            if (wr && ADR_I == `MIC_OFS_ENABLE)
                en_q[7:0] <= DAT_I[7:0];
            if (wb_hit && WE_I && SEL_I[1] && ADR_I == `MIC_OFS_ENABLE)
                en_q[13:8] <= DAT_I[13:8];
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end
        else
        begin
            ACK_O <= wb_hit;
            DAT_O <= 32'h0000_0000;
            if (wb_hit && !WE_I)
            begin
                case (ADR_I)
                    `MIC_OFS_SENS:    DAT_O <= {24'h000000, sens_q};
                    `MIC_OFS_ENABLE:  DAT_O <= {18'h00000, en_q};
                    `MIC_OFS_PENDING: DAT_O <= {18'h00000, req};
                    `MIC_OFS_STATUS:  DAT_O <= {26'h0000000, mode_q, mask_q};
                    default:          DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_trap_taken;
        TRAP_I && !rst_pend_q;
    endsequence
    sequence s_trap_shown;
        IRQ_O && VECTOR_O == 16'hFFFC;
    endsequence
    a_trap_vector: assert property (@(posedge CLK_I) disable iff (!rst_n)
        s_trap_taken |=> s_trap_shown)
        else $error("trap vector wrong");
    a_sens_locked: assert property (@(posedge CLK_I) disable iff (!rst_n)
        !mask_q && wr |=> $stable(sens_q))
        else $error("sensitivity written while unmasked");
    a_entry_mask: assert property (@(posedge CLK_I) disable iff (!rst_n)
        ENTRY_I |=> mask_q)
        else $error("mask not set on entry");
    a_masked_quiet: assert property (@(posedge CLK_I) disable iff (!rst_n)
        mask_q && !rst_pend_q && !trap_pend_q && !TRAP_I |=> !IRQ_O)
        else $error("request passed mask");
    a_pend_holds: assert property (@(posedge CLK_I) disable iff (!rst_n)
        pend_q[7] && !en_q[7] && !PERIPH_CLEAR_I[7] |=> pend_q[7])
        else $error("pending lost");
    a_clear_drops: assert property (@(posedge CLK_I) disable iff (!rst_n)
        PERIPH_CLEAR_I[9] |=> !pend_q[9])
        else $error("clear did not drop");
    a_halt_awu: assert property (@(posedge CLK_I) disable iff (!rst_n)
        mode_q == MIC_HALT && req[0] && req[4:1] == 4'h0 && !req[12]
        && !WFI_I && !HALT_I && !AHALT_I && !AUTO_WAKEUP_HALT_MODE_I |=> mode_q == MIC_HALT)
        else $error("auto-wakeup ended plain halt");
    a_halt_tb_two: assert property (@(posedge CLK_I) disable iff (!rst_n)
        mode_q == MIC_HALT && req[5] && (req & en_q & 14'h101E) == 14'h0000 |=> !WAKE_O)
        else $error("timebase two ended halt");
    a_ahalt_ovf: assert property (@(posedge CLK_I) disable iff (!rst_n)
        mode_q == MIC_AHALT && req[9] && en_q[9] && !WFI_I && !HALT_I && !AHALT_I && !AUTO_WAKEUP_HALT_MODE_I
        |=> WAKE_O)
        else $error("overflow did not wake active-halt");
    a_wait_wake: assert property (@(posedge CLK_I) disable iff (!rst_n)
        mode_q == MIC_WAIT && (req & en_q) != 14'h0000 && !WFI_I && !HALT_I && !AHALT_I && !AUTO_WAKEUP_HALT_MODE_I
        |=> WAKE_O)
        else $error("request did not end wait");
endmodule
`default_nettype wire

// File: mic_core_model.sv
// Purpose: Core model that enters service routines when a request is shown.
// Assumes: The core enters only while the mode is run.
// Notes:   Answers alternate between prompt and slow.
`default_nettype none
module mic_core_model
    import mic_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Controller outputs.
    input  wire logic        irq_i,
    input  wire logic [15:0] vector_i,
    input  wire logic        wake_i,
    input  wire logic [4:0]  mode_i,
    // Core side.
    output logic             entry_o,
    output logic      [15:0] taken_vec_o,
    output int               taken_cnt_o,
    output int               wake_cnt_o
);
    int   wait_q;
    logic slow_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            entry_o     <= 1'b0;
            taken_vec_o <= 16'h0000;
            taken_cnt_o <= 0;
            wake_cnt_o  <= 0;
            wait_q      <= 0;
            slow_q      <= 1'b0;
        end
        else
        begin
            entry_o <= 1'b0;
            if (wake_i)
                wake_cnt_o <= wake_cnt_o + 1;
            if (entry_o || !irq_i || mode_i != MIC_RUN)
                wait_q <= 0;
            else if (wait_q >= (slow_q ? 5 : 2))
            begin
                entry_o     <= 1'b1;
                taken_vec_o <= vector_i;
                taken_cnt_o <= taken_cnt_o + 1;
                slow_q      <= !slow_q;
                wait_q      <= 0;
            end
            else
                wait_q <= wait_q + 1;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the interrupt request controller.
// Assumes: The core model answers requests while the mode is run.
// Notes:   Each scenario leaves the global mask clear.
`include "mic_cfg.svh"
`default_nettype none
module testbench
    import mic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Signals.
    // ----------------------------------------
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h00000000;
    logic [3:0]  ext   = 4'hF;
    logic [13:0] flag  = 14'h0000;
    logic [13:0] clr   = 14'h0000;
    logic [5:0]  ev    = 6'h00;
    logic [31:0] dat_o, rd;
    logic        ack, irq, mask, wake, entry;
    logic [15:0] vec, tvec;
    logic [4:0]  mode;
    int          tcnt, wcnt;
    int          seen      = 0;
    int          err_count = 0;
    int          compares  = 0;

    always #25 clk = ~clk;

    mic_top dut
    (
        .CLK_I(clk), .RESETN_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .EXT_LINE_I(ext),
        .PERIPH_FLAG_I(flag), .PERIPH_CLEAR_I(clr), .TRAP_I(ev[0]), .ENTRY_I(entry),
        .RETURN_FROM_IRQ_INSTR_I(ev[1]), .WFI_I(ev[2]), .HALT_I(ev[3]), .AHALT_I(ev[4]), .AUTO_WAKEUP_HALT_MODE_I(ev[5]),
        .IRQ_O(irq), .VECTOR_O(vec), .MASK_O(mask), .WAKE_O(wake), .MODE_O(mode)
    );
    mic_core_model core
    (
        .clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .vector_i(vec), .wake_i(wake), .mode_i(mode),
        .entry_o(entry), .taken_vec_o(tvec), .taken_cnt_o(tcnt), .wake_cnt_o(wcnt)
    );
    // ----------------------------------------
    // Shared tasks.
    // ----------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang(input string nm);
        err_count++;
        $display("ERROR %s expected an answer seen none", nm);
        print_verdict();
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            hang("bus ack");
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    // Waits for the core model to enter a routine and checks its vector.
    task automatic ser(input logic [15:0] e);
        int n;
        n = 0;
        while (tcnt == seen && n < 60)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 60)
            hang("service entry");
        seen++;
        chk("vector", {16'h0000, e}, {16'h0000, tvec});
        repeat (2) @(posedge clk);
        chk("mask on entry", 32'h1, {31'h0, mask});
    endtask
    task automatic none();
        repeat (12) @(posedge clk);
        chk("service count", 32'(seen), 32'(tcnt));
    endtask
    task automatic done(input int s);
        @(posedge clk);
        flag[s] <= 1'b0;
        clr[s]  <= 1'b1;
        @(posedge clk);
        clr <= 14'h0000;
        pulse(1);
    endtask
    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    task automatic s_regs();
        ser(`MIC_VEC_RESET);
        pulse(0);
        ser(`MIC_VEC_TRAP);
        wb(1'b0, `MIC_OFS_SENS, 32'h0);
        chk("sensitivity reset", 32'h0, rd);
        wb(1'b1, `MIC_OFS_SENS, 32'hE4);
        wb(1'b1, `MIC_OFS_ENABLE, 32'h1F3F);
        wb(1'b0, `MIC_OFS_SENS, 32'h0);
        chk("sensitivity masked write", 32'hE4, rd);
        pulse(1);
        wb(1'b1, `MIC_OFS_SENS, 32'h1B);
        wb(1'b0, `MIC_OFS_SENS, 32'h0);
        chk("sensitivity open write", 32'hE4, rd);
        wb(1'b0, `MIC_OFS_STATUS, 32'h0);
        chk("status", 32'h2, rd);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask
    task automatic s_ext();
        ext[0] <= 1'b0;
        ser(16'hFFF8);
        pulse(1);
        ser(16'hFFF8);
        ext[0] <= 1'b1;
        pulse(1);
        none();
        ext[1] <= 1'b0;
        none();
        ext[1] <= 1'b1;
        ser(16'hFFF6);
        pulse(1);
        ext[2] <= 1'b0;
        ser(16'hFFF4);
        ext[2] <= 1'b1;
        pulse(1);
        none();
        ext[3] <= 1'b0;
        ser(16'hFFF2);
        pulse(1);
        ext[3] <= 1'b1;
        ser(16'hFFF2);
        pulse(1);
    endtask
    task automatic s_periph();
        flag[7] <= 1'b1;
        none();
        wb(1'b0, `MIC_OFS_PENDING, 32'h0);
        chk("pending while disabled", 32'h80, rd);
        wb(1'b1, `MIC_OFS_ENABLE, 32'h1FBF);
        ser(16'hFFEC);
        done(7);
        flag[6] <= 1'b1;
        none();
        done(6);
        wb(1'b1, `MIC_OFS_ENABLE, 32'h1FFF);
        none();
    endtask
    task automatic s_power();
        int w;
        w = wcnt;
        pulse(3);
        flag[0] <= 1'b1;
        flag[5] <= 1'b1;
        flag[9] <= 1'b1;
        none();
        chk("halt mode", {27'h0, MIC_HALT}, {27'h0, mode});
        flag[12] <= 1'b1;
        ser(16'hFFFA);
        done(0);
        ser(16'hFFF0);
        done(5);
        ser(16'hFFE8);
        done(9);
        ser(16'hFFE2);
        done(12);
        pulse(5);
        flag[0] <= 1'b1;
        ser(16'hFFFA);
        done(0);
        pulse(4);
        flag[8] <= 1'b1;
        flag[10] <= 1'b1;
        none();
        chk("active-halt mode", {27'h0, MIC_AHALT}, {27'h0, mode});
        flag[9] <= 1'b1;
        ser(16'hFFEA);
        done(8);
        ser(16'hFFE8);
        done(9);
        ser(16'hFFE6);
        done(10);
        pulse(4);
        flag[11] <= 1'b1;
        ser(16'hFFE4);
        done(11);
        pulse(2);
        flag[7] <= 1'b1;
        ser(16'hFFEC);
        done(7);
        chk("wake count", 32'(w + 5), 32'(wcnt));
    endtask
    // ----------------------------------------
    // Main sequence.
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_ext();
        s_periph();
        s_power();
        print_verdict();
    end
endmodule
`default_nettype wire
